// ===== hdl/volt_set_a_regs.sv
`timescale 1ns/1ps
module volt_set_a_regs (
  // Clock, reset, enable
  input  wire logic                                CORE_CLK,
  input  wire logic                                NRST,
  input  wire logic                                CLK_EN,
  // Wishbone slave
  input  wire logic                                CYC_I,
  input  wire logic                                STB_I,
  input  wire logic                                WE_I,
  input  wire logic [volt_set_a_pkg::WB_ADDR_W-1:0] ADR_I,
  input  wire logic [3:0]                          SEL_I,
  input  wire logic [31:0]                         DAT_I,
  output logic      [31:0]                         DAT_O,
  output logic                                     ACK_O,
  output logic                                     ERR_O,
  // Set selection and buck mode fields
  input  wire logic [volt_set_a_pkg::NUM_BUCKS-1:0] SET_B_SEL,
  input  wire logic [2*volt_set_a_pkg::NUM_BUCKS-1:0] BUCK_MODE_FIELD,
  // Rail controls
  output logic [volt_set_a_pkg::NUM_BUCKS-1:0]     BUCK_SLEEP,
  output logic [6:0]                               CORE1_BUCK_VOLTAGE_CODE_A,
  output logic [6:0]                               PROCESSOR_BUCK_VOLTAGE_CODE_A,
  output logic [6:0]                               MEMORY_BUCK_VOLTAGE_CODE_A,
  output logic [6:0]                               IO_BUCK_VOLTAGE_CODE_A,
  output logic [6:0]                               PERIPHERAL_BUCK_VOLTAGE_CODE_A,
  output logic [5:0]                               LINREG_ONE_VOLTAGE_CODE_A,
  output logic                                     LINREG_ONE_SLEEP_SEL_A
);
  import volt_set_a_pkg::*;

  logic [REG_W-1:0]     regs [NUM_RAILS];
  logic [REG_W-1:0]     next_rdata;
  logic [2:0]           hit_idx;
  logic                 hit;
  logic                 req;
  logic [7:0]           widx;
  logic [NUM_BUCKS-1:0] sleep_b_reg;
  logic [NUM_BUCKS-1:0] next_sleep;

  // Set B lives elsewhere; its sleep bit is tied to zero here
  assign sleep_b_reg = '0;
  assign widx        = ADR_I[WB_ADDR_W-1:2];
  assign req         = CYC_I && STB_I && !ACK_O && !ERR_O;

  always_comb begin
    hit     = 1'b1;
    hit_idx = 3'h0;
    case (widx)
      IDX_CORE1:   hit_idx = 3'h0;
      IDX_PROC:    hit_idx = 3'h1;
      IDX_MEM:     hit_idx = 3'h2;
      IDX_IO:      hit_idx = 3'h3;
      IDX_PERI:    hit_idx = 3'h4;
      IDX_LINREG1: hit_idx = 3'h5;
      default:     hit     = 1'b0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < NUM_RAILS; g++) begin : g_rail
      rail_set_reg #(
        .WMASK ((g == NUM_RAILS - 1) ? LINREG_WMASK : BUCK_WMASK)
      ) u_reg (
        .clk   (CORE_CLK),
        .nrst  (NRST),
        .en    (CLK_EN),
        .wr    (req && hit && WE_I && SEL_I[0] && (hit_idx == 3'(g))),
        .wdata (DAT_I[REG_W-1:0]),
        .value (regs[g])
      );
    end
  endgenerate

  assign next_rdata = hit ? regs[hit_idx] : REG_RESET;

  // One wait cycle; unmapped addresses answer with an error
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ACK_O <= 1'b0;
    end else if (CLK_EN) begin
      ACK_O <= req && hit;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ERR_O <= 1'b0;
    end else if (CLK_EN) begin
      ERR_O <= req && !hit;
    end
  end

  // Zero outside a read answer, so nothing stale shows on the bus
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      DAT_O <= 32'h0;
    end else if (CLK_EN) begin
      DAT_O <= {24'h0, (req && hit && !WE_I) ? next_rdata : 8'h00};
    end
  end

  // Effective sleep per buck
  always_comb begin
    for (int i = 0; i < NUM_BUCKS; i++) begin
      case (BUCK_MODE_FIELD[2*i +: 2])
        MODE_FOLLOW_SET: next_sleep[i] = SET_B_SEL[i] ? sleep_b_reg[i]
                                                       : regs[i][SLEEP_BIT];
        MODE_SLEEP:      next_sleep[i] = 1'b1;
        MODE_SYNC:       next_sleep[i] = 1'b0;
        MODE_AUTO:       next_sleep[i] = 1'b0;
        default:         next_sleep[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      BUCK_SLEEP                     <= '0;
      CORE1_BUCK_VOLTAGE_CODE_A      <= 7'h00;
      PROCESSOR_BUCK_VOLTAGE_CODE_A  <= 7'h00;
      MEMORY_BUCK_VOLTAGE_CODE_A     <= 7'h00;
      IO_BUCK_VOLTAGE_CODE_A         <= 7'h00;
      PERIPHERAL_BUCK_VOLTAGE_CODE_A <= 7'h00;
      LINREG_ONE_VOLTAGE_CODE_A      <= 6'h00;
      LINREG_ONE_SLEEP_SEL_A         <= 1'b0;
    end else if (CLK_EN) begin
      BUCK_SLEEP                     <= next_sleep;
      CORE1_BUCK_VOLTAGE_CODE_A      <= regs[0][6:0];
      PROCESSOR_BUCK_VOLTAGE_CODE_A  <= regs[1][6:0];
      MEMORY_BUCK_VOLTAGE_CODE_A     <= regs[2][6:0];
      IO_BUCK_VOLTAGE_CODE_A         <= regs[3][6:0];
      PERIPHERAL_BUCK_VOLTAGE_CODE_A <= regs[4][6:0];
      LINREG_ONE_VOLTAGE_CODE_A      <= regs[5][5:0];
      LINREG_ONE_SLEEP_SEL_A         <= regs[5][SLEEP_BIT];
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  sequence s_write_core1;
    CLK_EN && req && hit && WE_I && SEL_I[0] && widx == IDX_CORE1
      && BUCK_MODE_FIELD[1:0] == MODE_FOLLOW_SET && !SET_B_SEL[0];
  endsequence

  sequence s_core1_follow_held;
    CLK_EN && BUCK_MODE_FIELD[1:0] == MODE_FOLLOW_SET && !SET_B_SEL[0];
  endsequence

  a_core1_sleep_follow: assert property (
    s_write_core1 ##1 s_core1_follow_held |=> BUCK_SLEEP[0] == $past(DAT_I[SLEEP_BIT], 2))
    else $error("core1 buck sleep not following set A bit");
  a_core1_code: assert property (
    CLK_EN |=> CORE1_BUCK_VOLTAGE_CODE_A == $past(regs[0][6:0]))
    else $error("core1 code not tracking register");
  a_proc_sleep: assert property (
    CLK_EN && BUCK_MODE_FIELD[3:2] == MODE_FOLLOW_SET && !SET_B_SEL[1]
      |=> BUCK_SLEEP[1] == $past(regs[1][SLEEP_BIT]))
    else $error("processor buck sleep wrong");
  a_mem_sleep: assert property (
    CLK_EN && BUCK_MODE_FIELD[5:4] == MODE_FOLLOW_SET && !SET_B_SEL[2]
      |=> BUCK_SLEEP[2] == $past(regs[2][SLEEP_BIT]))
    else $error("memory buck sleep wrong");
  a_io_sleep: assert property (
    CLK_EN && BUCK_MODE_FIELD[7:6] == MODE_FOLLOW_SET && !SET_B_SEL[3]
      |=> BUCK_SLEEP[3] == $past(regs[3][SLEEP_BIT]))
    else $error("io buck sleep wrong");
  a_peri_sleep: assert property (
    CLK_EN && BUCK_MODE_FIELD[9:8] == MODE_FOLLOW_SET && !SET_B_SEL[4]
      |=> BUCK_SLEEP[4] == $past(regs[4][SLEEP_BIT]))
    else $error("peripheral buck sleep wrong");
  a_linreg_sleep: assert property (
    CLK_EN |=> LINREG_ONE_SLEEP_SEL_A == $past(regs[5][SLEEP_BIT]))
    else $error("linear regulator sleep wrong");
  a_linreg_rsvd: assert property (
    regs[5][LINREG_RSVD_BIT] == 1'b0)
    else $error("reserved bit set");
  a_proc_code: assert property (
    CLK_EN |=> PROCESSOR_BUCK_VOLTAGE_CODE_A == $past(regs[1][6:0]))
    else $error("processor code not tracking register");
  a_forced_mode: assert property (
    CLK_EN && BUCK_MODE_FIELD[1:0] == MODE_SLEEP |=> BUCK_SLEEP[0])
    else $error("forced sleep ignored");
  a_ack_one_wait: assert property (
    CLK_EN && req && hit |=> ACK_O ##1 (!ACK_O || $past(!CLK_EN)))
    else $error("ack timing wrong");

  // Bus phases shared by the checks below
  sequence s_write_take;
    CLK_EN && req && hit && WE_I && SEL_I[0];
  endsequence

  sequence s_lane_off_take;
    CLK_EN && req && hit && WE_I && !SEL_I[0];
  endsequence

  sequence s_read_take;
    CLK_EN && req && hit && !WE_I;
  endsequence

  sequence s_unmapped_take;
    CLK_EN && req && !hit;
  endsequence

  a_mem_code: assert property (
    CLK_EN |=> MEMORY_BUCK_VOLTAGE_CODE_A == $past(regs[2][6:0]))
    else $error("memory code not tracking register");
  a_io_code: assert property (
    CLK_EN |=> IO_BUCK_VOLTAGE_CODE_A == $past(regs[3][6:0]))
    else $error("io code not tracking register");
  a_peri_code: assert property (
    CLK_EN |=> PERIPHERAL_BUCK_VOLTAGE_CODE_A == $past(regs[4][6:0]))
    else $error("peripheral code not tracking register");
  a_linreg_code: assert property (
    CLK_EN |=> LINREG_ONE_VOLTAGE_CODE_A == $past(regs[5][5:0]))
    else $error("linear regulator code not tracking register");

  a_core1_write_lands: assert property (
    s_write_take ##0 widx == IDX_CORE1 |=> regs[0] == $past(DAT_I[REG_W-1:0]))
    else $error("core1 register write lost");
  a_proc_write_lands: assert property (
    s_write_take ##0 widx == IDX_PROC |=> regs[1] == $past(DAT_I[REG_W-1:0]))
    else $error("processor register write lost");
  a_mem_write_lands: assert property (
    s_write_take ##0 widx == IDX_MEM |=> regs[2] == $past(DAT_I[REG_W-1:0]))
    else $error("memory register write lost");
  a_io_write_lands: assert property (
    s_write_take ##0 widx == IDX_IO |=> regs[3] == $past(DAT_I[REG_W-1:0]))
    else $error("io register write lost");
  a_peri_write_lands: assert property (
    s_write_take ##0 widx == IDX_PERI |=> regs[4] == $past(DAT_I[REG_W-1:0]))
    else $error("peripheral register write lost");
  a_linreg_write_lands: assert property (
    s_write_take ##0 widx == IDX_LINREG1 |=> regs[5][SLEEP_BIT] == $past(DAT_I[SLEEP_BIT])
      && regs[5][5:0] == $past(DAT_I[5:0]) && !regs[5][LINREG_RSVD_BIT])
    else $error("linear regulator register write wrong");

  a_lane_off_keep: assert property (
    s_lane_off_take |=> $stable(regs[0]) && $stable(regs[1]) && $stable(regs[2])
      && $stable(regs[3]) && $stable(regs[4]) && $stable(regs[5]))
    else $error("write with lane off changed a register");
  a_lane_off_ack: assert property (
    s_lane_off_take |=> ACK_O && !ERR_O)
    else $error("write with lane off not acked");
  a_read_no_store: assert property (
    s_read_take |=> $stable(regs[0]) && $stable(regs[1]) && $stable(regs[2])
      && $stable(regs[3]) && $stable(regs[4]) && $stable(regs[5]))
    else $error("read changed a register");
  a_unmapped_keep: assert property (
    s_unmapped_take |=> $stable(regs[0]) && $stable(regs[1]) && $stable(regs[2])
      && $stable(regs[3]) && $stable(regs[4]) && $stable(regs[5]))
    else $error("unmapped access changed a register");
  a_unmapped_answer: assert property (
    s_unmapped_take |=> ERR_O && !ACK_O && DAT_O == 32'h0)
    else $error("unmapped access answered wrongly");
  a_err_one_wait: assert property (
    s_unmapped_take |=> ERR_O ##1 (!ERR_O || $past(!CLK_EN)))
    else $error("error timing wrong");

  a_read_data: assert property (
    s_read_take |=> ACK_O && DAT_O == {24'h0, $past(regs[hit_idx])})
    else $error("read data wrong");
  a_data_idle: assert property (
    !ACK_O |-> DAT_O == 32'h0)
    else $error("read data outside ack");
  a_ack_err_excl: assert property (
    !(ACK_O && ERR_O))
    else $error("ack and error together");
  a_ack_only_request: assert property (
    CLK_EN && !(req && hit) |=> !ACK_O)
    else $error("ack without request");
  a_err_only_request: assert property (
    CLK_EN && !(req && !hit) |=> !ERR_O)
    else $error("error without request");

  // Clock enable low holds the bank and every output
  a_frozen_bank: assert property (
    !CLK_EN |=> $stable(regs[0]) && $stable(regs[1]) && $stable(regs[2])
      && $stable(regs[3]) && $stable(regs[4]) && $stable(regs[5]))
    else $error("register changed while frozen");
  a_frozen_bus: assert property (
    !CLK_EN |=> $stable(ACK_O) && $stable(ERR_O) && $stable(DAT_O))
    else $error("bus answer changed while frozen");
  a_frozen_rails: assert property (
    !CLK_EN |=> $stable(BUCK_SLEEP) && $stable(LINREG_ONE_SLEEP_SEL_A)
      && $stable(CORE1_BUCK_VOLTAGE_CODE_A) && $stable(PROCESSOR_BUCK_VOLTAGE_CODE_A)
      && $stable(MEMORY_BUCK_VOLTAGE_CODE_A) && $stable(IO_BUCK_VOLTAGE_CODE_A)
      && $stable(PERIPHERAL_BUCK_VOLTAGE_CODE_A) && $stable(LINREG_ONE_VOLTAGE_CODE_A))
    else $error("rail output changed while frozen");

  // Fixed modes and the set B case for every buck
  for (genvar b = 0; b < NUM_BUCKS; b++) begin : g_mode_chk
    a_sleep_forced: assert property (
      CLK_EN && BUCK_MODE_FIELD[2*b +: 2] == MODE_SLEEP |=> BUCK_SLEEP[b])
      else $error("buck forced sleep ignored");
    a_sync_forced: assert property (
      CLK_EN && BUCK_MODE_FIELD[2*b +: 2] == MODE_SYNC |=> !BUCK_SLEEP[b])
      else $error("buck forced synchronous ignored");
    a_auto_awake: assert property (
      CLK_EN && BUCK_MODE_FIELD[2*b +: 2] == MODE_AUTO |=> !BUCK_SLEEP[b])
      else $error("buck automatic mode reports sleep");
    a_set_b_awake: assert property (
      CLK_EN && BUCK_MODE_FIELD[2*b +: 2] == MODE_FOLLOW_SET && SET_B_SEL[b]
        |=> !BUCK_SLEEP[b])
      else $error("buck set B sleep wrong");
  end
endmodule : volt_set_a_regs

// ===== inc/volt_set_a_pkg.sv
// Notes on behaviour
// - Bit 7 of the first core buck A register picks synchronous (0) or sleep (1) when set A is used.
// - Bits 6:0 of the first core buck A register are a voltage code from 0.30 V in 10 mV steps to 1.57 V.
// - Bit 7 of the processor buck A register picks sleep when set and synchronous when clear under set A.
// - Bit 7 of the memory buck A register picks sleep when set and synchronous when clear under set A.
// - Bit 7 of the I/O buck A register picks sleep when set and synchronous when clear under set A.
// - Bit 7 of the peripheral buck A register picks sleep when set and synchronous when clear under set A.
// - Bit 7 of the first linear regulator A register picks normal (0) or sleep (1) under set A.
// - Bits 5:0 of the first linear regulator A register are a code from 0.60 V in 20 mV steps; bit 6 is reserved.
// - With a buck mode field of 00, sleep or synchronous follows the mode bit of the selected set; with set B selected the code always gives synchronous.
package volt_set_a_pkg;
  localparam int          NUM_RAILS       = 6;
  localparam int          WB_ADDR_W       = 10;
  localparam int          REG_W           = 8;
  localparam logic [7:0]  IDX_CORE1       = 8'ha4;
  localparam logic [7:0]  IDX_PROC        = 8'ha5;
  localparam logic [7:0]  IDX_MEM         = 8'ha6;
  localparam logic [7:0]  IDX_IO          = 8'ha7;
  localparam logic [7:0]  IDX_PERI        = 8'ha8;
  localparam logic [7:0]  IDX_LINREG1     = 8'ha9;
  localparam int          SLEEP_BIT       = 7;
  localparam int          LINREG_RSVD_BIT = 6;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [7:0]  LINREG_WMASK    = 8'hbf;
  localparam logic [7:0]  BUCK_WMASK      = 8'hff;
  localparam logic [1:0]  MODE_FOLLOW_SET = 2'h0;
  localparam logic [1:0]  MODE_SLEEP      = 2'h1;
  localparam logic [1:0]  MODE_SYNC       = 2'h2;
  localparam logic [1:0]  MODE_AUTO       = 2'h3;
  localparam int          NUM_BUCKS       = 5;
endpackage : volt_set_a_pkg

// ===== hdl/rail_set_reg.sv
`timescale 1ns/1ps
module rail_set_reg
  import volt_set_a_pkg::*;
#(
  parameter logic [7:0] WMASK = 8'hff
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             en,
  input  wire logic             wr,
  input  wire logic [REG_W-1:0] wdata,
  output logic      [REG_W-1:0] value
);
  // Masked bits stay at reset value, so a reserved bit always reads zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value <= REG_RESET;
    end else if (en && wr) begin
      value <= wdata & WMASK;
    end
  end
endmodule : rail_set_reg

// ===== tb/volt_set_a_regs_tb.sv
`timescale 1ns/1ps
module volt_set_a_regs_tb;
  import volt_set_a_pkg::*;
  logic        clk, nrst, ce, cyc, stb, we;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_i, dat_o, rd;
  logic        ack, err, er, ln_sl;
  logic [4:0]  set_b, sleep, e;
  logic [9:0]  mode;
  logic [6:0]  c_core, c_proc, c_mem, c_io, c_peri;
  logic [5:0]  c_ln;
  logic [7:0]  d;
  logic [7:0]  model [NUM_RAILS];
  int          mismatches, checks, seed;

  volt_set_a_regs u_volt_set_a_regs (.CORE_CLK(clk), .NRST(nrst), .CLK_EN(ce), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o),
    .ACK_O(ack), .ERR_O(err), .SET_B_SEL(set_b), .BUCK_MODE_FIELD(mode), .BUCK_SLEEP(sleep),
    .CORE1_BUCK_VOLTAGE_CODE_A(c_core), .PROCESSOR_BUCK_VOLTAGE_CODE_A(c_proc),
    .MEMORY_BUCK_VOLTAGE_CODE_A(c_mem), .IO_BUCK_VOLTAGE_CODE_A(c_io),
    .PERIPHERAL_BUCK_VOLTAGE_CODE_A(c_peri), .LINREG_ONE_VOLTAGE_CODE_A(c_ln),
    .LINREG_ONE_SLEEP_SEL_A(ln_sl));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task summarize();
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Answer read at the edge, before the design updates it; only the watchdog ends a wait
  task wb(input logic w, input logic [9:0] a, input logic [7:0] v, input logic s0);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= {3'h0, s0}; dat_i <= {24'h0, v};
    @(posedge clk);
    while (ack !== 1'b1 && err !== 1'b1) @(posedge clk);
    rd = dat_o;
    er = err;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb

  function logic [4:0] exp_sleep();
    logic [4:0] r;
    for (int i = 0; i < 5; i++) r[i] = (mode[2*i+:2] == 2'h0) ? (!set_b[i] && model[i][7])
                                      : (mode[2*i+:2] == 2'h1);
    return r;
  endfunction : exp_sleep

  task outs();
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("core1 code", c_core, model[0][6:0]);
    check("proc code", c_proc, model[1][6:0]);
    check("mem code", c_mem, model[2][6:0]);
    check("io code", c_io, model[3][6:0]);
    check("peri code", c_peri, model[4][6:0]);
    check("linreg code", c_ln, model[5][5:0]);
    check("linreg sleep", ln_sl, model[5][7]);
    check("buck sleep", sleep, exp_sleep());
  endtask : outs

  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    summarize();
  end

  initial begin
    seed = 64;
    nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; dat_i = '0;
    set_b = '0; mode = '0;
    ce = 1'b1;
    foreach (model[i]) model[i] = REG_RESET;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    outs();
    for (int r = 0; r < 6; r++) begin
      @(posedge clk);
      set_b <= 5'($random(seed));
      mode <= 10'($random(seed));
      for (int i = 0; i < NUM_RAILS; i++) begin
        d = 8'($random(seed));
        wb(1'b1, 10'h290 + 10'(4 * i), d, 1'b1);
        model[i] = (i == 5) ? (d & LINREG_WMASK) : d;
      end
      for (int i = 0; i < NUM_RAILS; i++) begin
        wb(1'b0, 10'h290 + 10'(4 * i), 8'h00, 1'b1);
        check("reg read", rd, {24'h0, model[i]});
      end
      outs();
    end
    // Every buck follows set A, and every sleep bit flips
    @(posedge clk);
    mode <= '0;
    set_b <= '0;
    for (int i = 0; i < NUM_BUCKS; i++) begin
      d = ~model[i];
      wb(1'b1, 10'h290 + 10'(4 * i), d, 1'b1);
      model[i] = d;
    end
    outs();
    // Write with byte lane off must leave the register alone
    wb(1'b1, 10'h290, ~model[0], 1'b0);
    wb(1'b0, 10'h290, 8'h00, 1'b1);
    check("masked write", rd, {24'h0, model[0]});
    wb(1'b0, 10'h28c, 8'h00, 1'b1);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0);
    wb(1'b1, 10'h2a8, 8'hff, 1'b1);
    check("unmapped wr err", er, 1'b1);
    outs();
    // Clock enable low must hold the buck sleep outputs while the mode inputs move
    e = exp_sleep();
    @(posedge clk);
    ce <= 1'b0;
    mode <= ~mode;
    set_b <= ~set_b;
    repeat (4) @(posedge clk);
    check("frozen sleep", sleep, {27'h0, e});
    ce <= 1'b1;
    outs();
    // Reset in mid-run clears the whole bank
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (model[i]) model[i] = REG_RESET;
    outs();
    for (int i = 0; i < NUM_RAILS; i++) begin
      wb(1'b0, 10'h290 + 10'(4 * i), 8'h00, 1'b1);
      check("reset read", rd, {24'h0, REG_RESET});
    end
    summarize();
  end
endmodule : volt_set_a_regs_tb
